// ---- hdl/wwdt_params.svh ----
`ifndef WWDT_PARAMS_SVH
`define WWDT_PARAMS_SVH
// Register byte offsets
`define WWDT_MODE_OFF   8'h00
`define WWDT_TC_OFF     8'h04
`define WWDT_FEED_OFF   8'h08
`define WWDT_TV_OFF     8'h0C
`define WWDT_WARN_OFF   8'h10
`define WWDT_WIN_OFF    8'h14
`define WWDT_STAT_OFF   8'h18
`define WWDT_MASK_OFF   8'h1C
// Mode field positions
`define WWDT_M_EN       0
`define WWDT_M_RSTEN    1
`define WWDT_M_RFLAG    2
`define WWDT_M_WINEN    3
`define WWDT_M_WARNEN   4
`define WWDT_M_CLKSEL   5
`define WWDT_M_KEEPOSC  6
// Status field positions
`define WWDT_S_TOUT     0
`define WWDT_S_WARN     1
`define WWDT_S_FEEDERR  2
`define WWDT_S_WINERR   3
// Reset values and constants
`define WWDT_TC_RST     24'hFFFFFF
`define WWDT_TC_MIN     24'h0000FF
`define WWDT_WARN_RST   24'h000000
`define WWDT_WIN_RST    24'hFFFFFF
`define WWDT_FEED_KEY1  8'hAA
`define WWDT_FEED_KEY2  8'h55
`define WWDT_PRESCALE   2'h3
`endif

// ---- hdl/wwdt_pkg.sv ----
`default_nettype none
package wwdt_pkg;
    // Software mode bits
    typedef struct packed {
        logic keep_osc;   // Keep watchdog osc in deep sleep
        logic clk_sel;    // 1: dedicated osc, 0: internal RC
        logic warn_en;    // Warning interrupt enable
        logic win_en;     // Windowed operation
        logic rst_flag;   // Last failure reset the chip
        logic rst_en;     // Failure resets rather than interrupts
        logic enable;     // Set-only enable
    } wwdt_mode_t;
    // Sticky event bits
    typedef struct packed {
        logic win_err;
        logic feed_err;
        logic warn;
        logic tout;
    } wwdt_stat_t;
    // Feed sequence tracker
    typedef enum logic [1:0] {
        WWDT_FEED_IDLE  = 2'b01,
        WWDT_FEED_ARMED = 2'b10
    } wwdt_feed_t;
endpackage
`default_nettype wire

// ---- hdl/wwdt_tick.sv ----
`default_nettype none
`include "wwdt_params.svh"
// Picks the watchdog tick source and divides by four
module wwdt_tick
    import wwdt_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic internal_rc_osc,
    input  wire logic dedicated_wdog_osc,
    input  wire logic clk_sel,
    output logic      tick
);
    logic [1:0] sync_a;      // Internal RC synchroniser
    logic [1:0] sync_b;      // Dedicated osc synchroniser
    logic       src_q;       // Previous selected level
    logic [1:0] pre;         // Divide-by-four count
    logic       next_src_q;
    logic [1:0] next_pre;
    logic       next_tick;
    logic       src;

    ////////////////////////////////////////////////////////////////
    // Next values; only the second flops feed logic
    always_comb begin
        src = clk_sel ? sync_b[1] : sync_a[1];
        next_src_q = src;
        next_pre = pre;
        next_tick = 1'b0;
        // Rising edge of the selected source
        if (src && !src_q) begin
            next_pre = pre + 2'h1;
            next_tick = (pre == `WWDT_PRESCALE);
        end
    end

    // Registers; a source switch may cost one partial tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
            src_q <= 1'b0;
            pre <= 2'h0;
            tick <= 1'b0;
        end else begin
            sync_a <= {sync_a[0], internal_rc_osc};
            sync_b <= {sync_b[0], dedicated_wdog_osc};
            src_q <= next_src_q;
            pre <= next_pre;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/wwdt_top.sv ----
// The register addresses and register access over APB were decided locally.
`default_nettype none
`include "wwdt_params.svh"
module wwdt_top
    import wwdt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        internal_rc_osc,
    input  wire logic        dedicated_wdog_osc,
    input  wire logic        deep_sleep,
    output logic             wdog_osc_power,
    output logic             wdog_tick_source,
    output logic             chip_reset,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////
    // State
    wwdt_mode_t  mode;          // Mode bits
    logic [23:0] tc;            // Time-out reload value
    logic [23:0] cnt;           // Running count
    logic [23:0] warn_at;       // Warning compare value
    logic [23:0] win;           // Window bound
    wwdt_stat_t  stat;          // Sticky events
    wwdt_stat_t  mask;          // Interrupt mask
    wwdt_feed_t  feed;          // Feed sequence
    logic        running;       // Started by first feed
    logic        sel_q;         // Pin synchronisers
    logic        sel_qq;
    logic        tick;          // Prescaled count enable

    wwdt_mode_t  next_mode;
    logic [23:0] next_tc;
    logic [23:0] next_cnt;
    logic [23:0] next_warn_at;
    logic [23:0] next_win;
    wwdt_stat_t  next_stat;
    wwdt_stat_t  next_mask;
    wwdt_feed_t  next_feed;
    logic        next_running;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        next_chip_reset;

    // Decode helpers
    logic        setup;         // APB setup cycle
    logic        done;          // APB transfer completes
    logic        wr;
    logic        rd;
    logic        feed_ok;       // Completed keyed feed
    logic        feed_bad;      // Broken feed sequence
    logic        win_bad;       // Feed too early
    logic        tout;          // Count expired
    logic        fail;          // Any watchdog failure

    // Widen a 24-bit value onto the bus
    function automatic logic [31:0] w24(input logic [23:0] v);
        return {8'h00, v};
    endfunction

    // Known register address
    function automatic logic mapped(input logic [7:0] a);
        return a == `WWDT_MODE_OFF || a == `WWDT_TC_OFF ||
               a == `WWDT_FEED_OFF || a == `WWDT_TV_OFF ||
               a == `WWDT_WARN_OFF || a == `WWDT_WIN_OFF ||
               a == `WWDT_STAT_OFF || a == `WWDT_MASK_OFF;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Tick source
    wwdt_tick u_tick (
        .pclk               (pclk),
        .presetn            (presetn),
        .internal_rc_osc    (internal_rc_osc),
        .dedicated_wdog_osc (dedicated_wdog_osc),
        .clk_sel            (mode.clk_sel),
        .tick               (tick)
    );

    // Zero-wait slave; answer prepared in the setup cycle
    assign pready = 1'b1;
    assign setup = psel && !penable;
    assign done = psel && penable;
    assign wr = done && pwrite;
    assign rd = done && !pwrite;

    ////////////////////////////////////////////////////////////////
    // Feed and failure decode
    always_comb begin
        feed_ok = 1'b0;
        feed_bad = 1'b0;
        // Second key right after the first
        if (feed == WWDT_FEED_ARMED && done) begin
            if (wr && paddr == `WWDT_FEED_OFF && pwdata[7:0] == `WWDT_FEED_KEY2)
                feed_ok = 1'b1;
            else if (!(wr && paddr == `WWDT_FEED_OFF && pwdata[7:0] == `WWDT_FEED_KEY1))
                feed_bad = 1'b1;
        end else if (wr && paddr == `WWDT_FEED_OFF && pwdata[7:0] != `WWDT_FEED_KEY1) begin
            feed_bad = 1'b1;
        end
        // Only punished while enabled
        feed_bad = feed_bad && mode.enable;
        win_bad = feed_ok && running && mode.win_en && cnt > win;
        tout = running && tick && cnt == 24'h000000;
        fail = mode.enable && (tout || feed_bad || win_bad);
    end

    ////////////////////////////////////////////////////////////////
    // Next-state logic for registers, counter and bus
    always_comb begin
        next_mode = mode;
        next_tc = tc;
        next_cnt = cnt;
        next_warn_at = warn_at;
        next_win = win;
        next_stat = stat;
        next_mask = mask;
        next_feed = feed;
        next_running = running;
        next_prdata = prdata;
        next_pslverr = pslverr;
        next_chip_reset = 1'b0;

        // Feed tracker: any other access cancels an armed key
        if (wr && paddr == `WWDT_FEED_OFF && pwdata[7:0] == `WWDT_FEED_KEY1)
            next_feed = WWDT_FEED_ARMED;
        else if (done)
            next_feed = WWDT_FEED_IDLE;

        // Register writes
        if (wr) begin
            if (paddr == `WWDT_MODE_OFF) begin
                // Enable can only be set here
                next_mode.enable = mode.enable | pwdata[`WWDT_M_EN];
                next_mode.rst_en = pwdata[`WWDT_M_RSTEN];
                next_mode.win_en = pwdata[`WWDT_M_WINEN];
                next_mode.warn_en = pwdata[`WWDT_M_WARNEN];
                next_mode.clk_sel = pwdata[`WWDT_M_CLKSEL];
                next_mode.keep_osc = pwdata[`WWDT_M_KEEPOSC];
                // Writing zero clears the reset flag
                if (!pwdata[`WWDT_M_RFLAG])
                    next_mode.rst_flag = 1'b0;
            end else if (paddr == `WWDT_TC_OFF) begin
                // Clamp to the 256-step floor
                if (pwdata[23:0] < `WWDT_TC_MIN)
                    next_tc = `WWDT_TC_MIN;
                else
                    next_tc = pwdata[23:0];
            end else if (paddr == `WWDT_WARN_OFF) begin
                next_warn_at = pwdata[23:0];
            end else if (paddr == `WWDT_WIN_OFF) begin
                next_win = pwdata[23:0];
            end else if (paddr == `WWDT_MASK_OFF) begin
                next_mask = pwdata[3:0];
            end
        end

        // Reading status clears it
        if (rd && paddr == `WWDT_STAT_OFF)
            next_stat = '0;

        // Count down on every prescaled tick while running, holding at zero
        if (running && tick && cnt != 24'h000000)
            next_cnt = cnt - 24'h000001;
        // Warning as the count lands on the compare value
        if (mode.warn_en && running && tick && cnt == warn_at + 24'h000001)
            next_stat.warn = 1'b1;

        // Good feed reloads and starts the count
        if (feed_ok && mode.enable && !win_bad) begin
            next_cnt = tc;
            next_running = 1'b1;
        end

        // Failure: reset or interrupt, then disable
        if (fail) begin
            next_mode.enable = 1'b0;
            next_running = 1'b0;
            next_cnt = tc;
            if (mode.rst_en) begin
                next_chip_reset = 1'b1;
                next_mode.rst_flag = 1'b1;
            end else begin
                next_stat.tout = next_stat.tout | tout;
                next_stat.feed_err = next_stat.feed_err | feed_bad;
                next_stat.win_err = next_stat.win_err | win_bad;
            end
        end

        // Read data and error, captured in setup
        if (setup) begin
            next_pslverr = !mapped(paddr);
            next_prdata = 32'h00000000;
            if (!pwrite) begin
                if (paddr == `WWDT_MODE_OFF)
                    next_prdata = {25'h0, mode};
                else if (paddr == `WWDT_TC_OFF)
                    next_prdata = w24(tc);
                else if (paddr == `WWDT_TV_OFF)
                    next_prdata = w24(cnt);
                else if (paddr == `WWDT_WARN_OFF)
                    next_prdata = w24(warn_at);
                else if (paddr == `WWDT_WIN_OFF)
                    next_prdata = w24(win);
                else if (paddr == `WWDT_STAT_OFF)
                    next_prdata = {28'h0000000, stat};
                else if (paddr == `WWDT_MASK_OFF)
                    next_prdata = {28'h0000000, mask};
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= '0;
            tc <= `WWDT_TC_RST;
            cnt <= `WWDT_TC_RST;
            warn_at <= `WWDT_WARN_RST;
            win <= `WWDT_WIN_RST;
            stat <= '0;
            mask <= '0;
            feed <= WWDT_FEED_IDLE;
            running <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            chip_reset <= 1'b0;
            irq <= 1'b0;
        end else begin
            mode <= next_mode;
            tc <= next_tc;
            cnt <= next_cnt;
            warn_at <= next_warn_at;
            win <= next_win;
            stat <= next_stat;
            mask <= next_mask;
            feed <= next_feed;
            running <= next_running;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            chip_reset <= next_chip_reset;
            irq <= |(next_stat & next_mask);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Oscillator controls; deep-sleep arrives from another domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 1'b0;
            sel_qq <= 1'b0;
            wdog_osc_power <= 1'b1;
            wdog_tick_source <= 1'b0;
        end else begin
            sel_q <= deep_sleep;
            sel_qq <= sel_q;
            // Osc stops in deep sleep unless kept on
            wdog_osc_power <= !sel_qq || mode.keep_osc;
            wdog_tick_source <= mode.clk_sel;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    // Access phases of two transfers are never adjacent: a setup, and at most one idle, lie between
    sequence s_feed_pair;
        wr && paddr == `WWDT_FEED_OFF && pwdata[7:0] == `WWDT_FEED_KEY1
        ##[2:3] wr && paddr == `WWDT_FEED_OFF && pwdata[7:0] == `WWDT_FEED_KEY2
            && mode.enable && !win_bad && !tout;
    endsequence

    a_timeout_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (tout && mode.enable && mode.rst_en) |=> chip_reset && mode.rst_flag && !mode.enable)
        else $error("time-out did not reset the chip");
    a_window_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && paddr == `WWDT_WIN_OFF) |=> $stable(win))
        else $error("window bound changed without a write");
    a_warn_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (mode.warn_en && running && tick && cnt == warn_at + 24'h000001 && !fail) |=> stat.warn)
        else $error("warning not raised");
    a_enable_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (mode.enable && !fail) |=> mode.enable)
        else $error("enable dropped without failure");
    a_bad_feed: assert property (@(posedge pclk) disable iff (!presetn)
        (feed_bad && !mode.rst_en) |=> stat.feed_err && !mode.enable)
        else $error("bad feed not flagged");
    a_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
        (running && tick && cnt != 24'h000000 && !feed_ok && !fail) |=> cnt == $past(cnt) - 24'h000001)
        else $error("counter did not step by one");
    a_tc_floor: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == `WWDT_TC_OFF && pwdata[23:0] < `WWDT_TC_MIN) |=> tc == `WWDT_TC_MIN)
        else $error("short time-out not clamped to 256 steps");
    a_feed_reload: assert property (@(posedge pclk) disable iff (!presetn)
        s_feed_pair |=> cnt == tc && running)
        else $error("valid feed did not reload");
    a_window_fail: assert property (@(posedge pclk) disable iff (!presetn)
        (mode.enable && win_bad) |=> !mode.enable && (chip_reset || stat.win_err))
        else $error("early feed not treated as failure");
endmodule
`default_nettype wire

// ---- verification/windowed_watchdog_timer_bench.sv ----
`default_nettype none
`include "wwdt_params.svh"
module windowed_watchdog_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Design-facing signals
    logic        pclk;               // 50 MHz bus clock
    logic        presetn;            // Async reset, active low
    logic        psel;               // APB select
    logic        penable;            // APB access phase
    logic        pwrite;             // APB direction
    logic [7:0]  paddr;              // APB byte address
    logic [31:0] pwdata;             // APB write data
    logic        pready;             // Slave ready
    logic [31:0] prdata;             // Slave read data
    logic        pslverr;            // Slave error
    logic        internal_rc_osc;    // Slow RC oscillator model
    logic        dedicated_wdog_osc; // Slow dedicated oscillator model
    logic        deep_sleep;         // Chip power state
    logic        wdog_osc_power;     // Dedicated oscillator supply
    logic        wdog_tick_source;   // Selected source mirror
    logic        chip_reset;         // Watchdog reset request
    logic        irq;                // Interrupt level
    // Bench bookkeeping
    int          err_total   = 0;    // Mismatches
    int          checks_done = 0;    // Comparisons
    int          cyc         = 0;    // Elapsed clock cycles
    int          rst_seen    = 0;    // Cycles with reset request high
    int          rc_cnt      = 0;    // RC half-period counter
    int          wo_cnt      = 0;    // Dedicated half-period counter
    int          i;                  // Poll index
    logic [31:0] rd;                 // Last read data
    logic        er;                 // Last slave error
    // Generous ceiling: the two long time-outs need about 25k cycles
    localparam int CYC_LIMIT = 60000;

    wwdt_top u_dut (
        .pclk               (pclk),
        .presetn            (presetn),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .pready             (pready),
        .prdata             (prdata),
        .pslverr            (pslverr),
        .internal_rc_osc    (internal_rc_osc),
        .dedicated_wdog_osc (dedicated_wdog_osc),
        .deep_sleep         (deep_sleep),
        .wdog_osc_power     (wdog_osc_power),
        .wdog_tick_source   (wdog_tick_source),
        .chip_reset         (chip_reset),
        .irq                (irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Oscillators well below pclk/4 so the synchroniser never loses an edge
    always @(posedge pclk) begin
        rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
        wo_cnt <= (wo_cnt == 6) ? 0 : wo_cnt + 1;
        if (rc_cnt == 4) internal_rc_osc <= ~internal_rc_osc;
        if (wo_cnt == 6) dedicated_wdog_osc <= ~dedicated_wdog_osc;
        // Counting high cycles shows a stretched pulse as an extra request
        if (chip_reset === 1'b1) rst_seen <= rst_seen + 1;
        cyc <= cyc + 1;
        if (cyc == CYC_LIMIT) begin
            err_total++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task chk1(input logic seen, input logic exp);
        chk({31'h0, seen}, {31'h0, exp});
    endtask

    // One APB transfer; request held until pready is sampled high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Keyed pair, back to back
    task feed();
        wr(`WWDT_FEED_OFF, {24'h0, `WWDT_FEED_KEY1});
        wr(`WWDT_FEED_OFF, {24'h0, `WWDT_FEED_KEY2});
    endtask

    // Bounded wait for either failure response
    task wait_evt(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge pclk);
            if (irq === 1'b1 || chip_reset === 1'b1) break;
        end
        repeat (2) @(posedge pclk);
    endtask

    task test_done();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        internal_rc_osc = 1'b0;
        dedicated_wdog_osc = 1'b0;
        deep_sleep = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values
        rd_chk(`WWDT_MODE_OFF, 32'h0);
        chk1(er, 1'b0);
        chk1(pready, 1'b1);
        rd_chk(`WWDT_TC_OFF, 32'hFFFFFF);
        rd_chk(`WWDT_TV_OFF, 32'hFFFFFF);
        rd_chk(`WWDT_WARN_OFF, 32'h0);
        rd_chk(`WWDT_WIN_OFF, 32'hFFFFFF);
        rd_chk(`WWDT_STAT_OFF, 32'h0);
        rd_chk(`WWDT_MASK_OFF, 32'h0);
        rd_chk(`WWDT_FEED_OFF, 32'h0);
        // Unmapped place answers with an error and zero data
        rd_chk(8'h20, 32'h0);
        chk1(er, 1'b1);
        // Time-out floor and 24-bit field
        wr(`WWDT_TC_OFF, 32'h10);
        rd_chk(`WWDT_TC_OFF, 32'hFF);
        wr(`WWDT_TC_OFF, 32'hAB000100);
        rd_chk(`WWDT_TC_OFF, 32'h100);
        wr(`WWDT_TC_OFF, 32'hFF);
        wr(`WWDT_WIN_OFF, 32'h80);
        rd_chk(`WWDT_WIN_OFF, 32'h80);
        wr(`WWDT_WARN_OFF, 32'hFC);
        rd_chk(`WWDT_WARN_OFF, 32'hFC);
        wr(`WWDT_MASK_OFF, 32'hD);
        // Oscillator choice and sleep supply
        @(posedge pclk);
        deep_sleep <= 1'b1;
        repeat (6) @(posedge pclk);
        chk1(wdog_osc_power, 1'b0);
        wr(`WWDT_MODE_OFF, 32'h60);
        repeat (6) @(posedge pclk);
        chk1(wdog_osc_power, 1'b1);
        chk1(wdog_tick_source, 1'b1);
        deep_sleep <= 1'b0;
        wr(`WWDT_MODE_OFF, 32'h0);
        repeat (6) @(posedge pclk);
        chk1(wdog_tick_source, 1'b0);
        ////////////////////////////////////////////////////////////////////////////////
        // Set-only enable, bad key, interrupt response and read-clear
        wr(`WWDT_MODE_OFF, 32'h1);
        wr(`WWDT_MODE_OFF, 32'h0);
        rd_chk(`WWDT_MODE_OFF, 32'h1);
        feed();
        xfer(1'b0, `WWDT_TV_OFF, 32'h0);
        chk1(rd inside {[32'hFD:32'hFF]}, 1'b1);
        wr(`WWDT_FEED_OFF, 32'h12);
        wait_evt(20);
        chk1(irq, 1'b1);
        rd_chk(`WWDT_MODE_OFF, 32'h0);
        rd_chk(`WWDT_STAT_OFF, 32'h4);
        rd_chk(`WWDT_STAT_OFF, 32'h0);
        repeat (2) @(posedge pclk);
        chk1(irq, 1'b0);
        ////////////////////////////////////////////////////////////////////////////////
        // Early feed inside window mode is a failure
        wr(`WWDT_MODE_OFF, 32'h1);
        feed();
        wr(`WWDT_MODE_OFF, 32'h9);
        feed();
        wait_evt(20);
        rd_chk(`WWDT_MODE_OFF, 32'h8);
        rd_chk(`WWDT_STAT_OFF, 32'h8);
        // Feed below the bound is accepted and reloads
        wr(`WWDT_MODE_OFF, 32'h11);
        feed();
        wr(`WWDT_MODE_OFF, 32'h19);
        for (i = 0; i < 3000; i++) begin
            xfer(1'b0, `WWDT_TV_OFF, 32'h0);
            if (rd < 32'h7C) break;
        end
        feed();
        rd_chk(`WWDT_STAT_OFF, 32'h2);
        xfer(1'b0, `WWDT_TV_OFF, 32'h0);
        chk1(rd inside {[32'hFD:32'hFF]}, 1'b1);
        // Warning is masked out, time-out is not
        repeat (400) @(posedge pclk);
        chk1(irq, 1'b0);
        wait_evt(12000);
        chk1(irq, 1'b1);
        rd_chk(`WWDT_STAT_OFF, 32'h3);
        rd_chk(`WWDT_MODE_OFF, 32'h18);
        ////////////////////////////////////////////////////////////////////////////////
        // Reset response: broken pair, then a full time-out
        wr(`WWDT_MODE_OFF, 32'h3);
        wr(`WWDT_FEED_OFF, {24'h0, `WWDT_FEED_KEY1});
        xfer(1'b0, `WWDT_MODE_OFF, 32'h0);
        wr(`WWDT_FEED_OFF, {24'h0, `WWDT_FEED_KEY2});
        wait_evt(20);
        chk(rst_seen, 32'h1);
        rd_chk(`WWDT_MODE_OFF, 32'h6);
        rd_chk(`WWDT_STAT_OFF, 32'h0);
        chk1(irq, 1'b0);
        // Dedicated source: 256 ticks of 56 cycles, later than an RC-timed run would end
        wr(`WWDT_MODE_OFF, 32'h23);
        rd_chk(`WWDT_MODE_OFF, 32'h23);
        feed();
        repeat (12000) @(posedge pclk);
        chk(rst_seen, 32'h1);
        wait_evt(4000);
        chk(rst_seen, 32'h2);
        rd_chk(`WWDT_MODE_OFF, 32'h26);
        test_done();
    end
endmodule
`default_nettype wire
